// file: verilog/clic_pkg.sv
/*
  Constants, types and shared decode functions for the cache lock and invalidate control.
  Assumes a 32-bit core word and the core's big-endian bit numbering mapped to LSB positions.
*/
package clic_pkg;

  localparam int unsigned DATA_W    = 32;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned ATTR_W    = 4;
  localparam int unsigned WAYS      = 8;
  localparam int unsigned WAY_W     = 3;
  localparam int unsigned SETS      = 128;
  localparam int unsigned SET_W     = 7;
  localparam int unsigned OFFS_W    = 5;
  localparam int unsigned DW_OFFS_W = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CFG_A  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CFG_B  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MSTATE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IBXU   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IBXL   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DBXU   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_DBXL   = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h20;

  // Field positions; big-endian bit n sits at LSB position 31-n
  localparam int unsigned CFGA_IC_EN   = 15;
  localparam int unsigned CFGA_DC_EN   = 14;
  localparam int unsigned CFGA_DLOCK   = 12;
  localparam int unsigned CFGA_FINV    = 10;
  localparam int unsigned CFGB_DWLK_LO = 5;
  localparam int unsigned MS_EXTI      = 15;
  localparam int unsigned MS_MCHK      = 12;
  localparam int unsigned MS_FPX0      = 11;
  localparam int unsigned MS_FPX1      = 8;
  localparam int unsigned MS_CE        = 7;
  localparam int unsigned MS_IXL       = 5;
  localparam int unsigned MS_DXL       = 4;
  localparam int unsigned BXU_BEPI_LO  = 17;
  localparam int unsigned BXU_BL_LO    = 2;
  localparam int unsigned BL_W         = 11;
  localparam int unsigned BXU_VS       = 1;
  localparam int unsigned BXL_ATTR_LO  = 3;
  localparam int unsigned ATTR_INHIBIT = 2;
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_VICT_LO = 4;

  // Reset values
  localparam logic [DATA_W-1:0] RST_CFG_A  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_CFG_B  = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_MSTATE = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_BX     = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_FLASH = 2'b10
  } clic_state_t;

  function automatic logic [SET_W-1:0] setOf(input logic [DATA_W-1:0] addr);
    setOf = addr[OFFS_W +: SET_W];
  endfunction : setOf

  // One entry format serves instruction and data side alike
  function automatic logic [ATTR_W-1:0] attrSel(input logic [DATA_W-1:0] upper,
                                                input logic [DATA_W-1:0] lower,
                                                input logic [DATA_W-1:0] ea,
                                                input logic              xlateOn,
                                                input logic [ATTR_W-1:0] pageAttr);
    logic [BL_W-1:0] keep;
    logic            hit;
    keep = ~upper[BXU_BL_LO +: BL_W];
    hit  = upper[BXU_VS]
           && (ea[DATA_W-1:BXU_BEPI_LO+BL_W] == upper[DATA_W-1:BXU_BEPI_LO+BL_W])
           && ((ea[BXU_BEPI_LO +: BL_W] & keep) == (upper[BXU_BEPI_LO +: BL_W] & keep));
    attrSel = (xlateOn && hit) ? lower[BXL_ATTR_LO +: ATTR_W] : pageAttr;
  endfunction : attrSel

endpackage : clic_pkg

// file: verilog/clic_valid_mem.sv
/*
  Valid-bit store, one word of way bits per set, bit-masked write, registered read.
  Assumes the controller drives at most one write per cycle.
*/
`timescale 1ns/100ps
module clic_valid_mem (
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  input  wire logic                       ce,
  input  wire logic                       wrEn,
  input  wire logic [clic_pkg::SET_W-1:0] wrAddr,
  input  wire logic [clic_pkg::WAYS-1:0]  wrMask,
  input  wire logic [clic_pkg::WAYS-1:0]  wrData,
  input  wire logic [clic_pkg::SET_W-1:0] rdAddr,
  output logic      [clic_pkg::WAYS-1:0]  rdData
);
  import clic_pkg::*;

  logic [WAYS-1:0] mem [SETS];
  logic [WAYS-1:0] rdData_reg;

  // Masked write avoids a read-modify-write on single-way updates
  always_ff @(posedge mclk) begin
    if (ce && wrEn) begin
      mem[wrAddr] <= (mem[wrAddr] & ~wrMask) | (wrData & wrMask);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdData_reg <= '0;
    end else if (ce) begin
      rdData_reg <= mem[rdAddr];
    end
  end

  assign rdData = rdData_reg;

endmodule : clic_valid_mem

// file: verilog/clic_victim.sv
/*
  Round-robin victim way picker that skips the locked low ways.
  Assumes locked ways are always ways 0 .. lockCount-1.
*/
`timescale 1ns/100ps
module clic_victim (
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  input  wire logic                       ce,
  input  wire logic [clic_pkg::WAY_W-1:0] lockCount,
  input  wire logic                       advance,
  output logic      [clic_pkg::WAY_W-1:0] victimWay
);
  import clic_pkg::*;

  localparam logic [WAY_W-1:0] LAST_WAY = 3'h7;

  logic [WAY_W-1:0] ptr_reg;

  // Never below the lock boundary; the top way is never lockable
  assign victimWay = (ptr_reg < lockCount) ? lockCount : ptr_reg;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ptr_reg <= '0;
    end else if (ce && advance) begin
      ptr_reg <= (victimWay == LAST_WAY) ? 3'h0 : victimWay + 3'h1;
    end
  end

endmodule : clic_victim

// file: verilog/clic_ctrl.sv
/*
  Cache lock and invalidate control: config, machine-state and block translation
  registers, data-cache flash and block invalidate, lock-aware allocation, instruction
  prefetch allocation and doubleword fetch addressing.
  Assumes tag lookup, data arrays and the bus unit live outside and use these ports.
*/
`timescale 1ns/100ps
module clic_ctrl (
  input  wire logic                        mclk,
  input  wire logic                        rst_b,
  input  wire logic                        ce,
  input  wire logic [clic_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [clic_pkg::DATA_W-1:0] regWrData,
  input  wire logic                        regWr,
  input  wire logic                        regRd,
  output logic      [clic_pkg::DATA_W-1:0] regRdData,
  output logic                             icacheEn,
  output logic                             dcacheEn,
  output logic                             instrXlateEn,
  output logic                             dataXlateEn,
  output logic                             externalIrqEn,
  output logic                             machineCheckEn,
  output logic                             fpExcMode0,
  output logic                             fpExcMode1,
  output logic                             critIrqEn,
  input  wire logic                        dMissValid,
  output logic                             dMissReady,
  input  wire logic [clic_pkg::DATA_W-1:0] dMissAddr,
  input  wire logic [clic_pkg::ATTR_W-1:0] dMissPageAttr,
  output logic                             dAllocValid,
  output logic      [clic_pkg::WAY_W-1:0]  dAllocWay,
  input  wire logic                        dBlkInvValid,
  output logic                             dBlkInvReady,
  input  wire logic [clic_pkg::DATA_W-1:0] dBlkInvAddr,
  input  wire logic [clic_pkg::WAY_W-1:0]  dBlkInvWay,
  input  wire logic [clic_pkg::DATA_W-1:0] dLookupAddr,
  output logic      [clic_pkg::WAYS-1:0]   dLookupValid,
  input  wire logic                        iFillValid,
  input  wire logic [clic_pkg::DATA_W-1:0] iFillAddr,
  input  wire logic [clic_pkg::ATTR_W-1:0] iFillPageAttr,
  output logic                             iAllocValid,
  output logic      [clic_pkg::WAY_W-1:0]  iAllocWay,
  input  wire logic [clic_pkg::DATA_W-1:0] iLookupAddr,
  output logic      [clic_pkg::WAYS-1:0]   iLookupValid,
  input  wire logic [clic_pkg::DATA_W-1:0] fetchPc,
  input  wire logic                        brValid,
  input  wire logic                        brTakenHint,
  input  wire logic [clic_pkg::DATA_W-1:0] brTarget,
  output logic      [clic_pkg::DATA_W-1:0] fetchDwAddr,
  output logic                             fetchSpec
);
  import clic_pkg::*;

  localparam logic [SET_W-1:0] LAST_SET = 7'h7F;

  logic [DATA_W-1:0] cfgA_reg;
  logic [DATA_W-1:0] cfgB_reg;
  logic [DATA_W-1:0] mstate_reg;
  logic [DATA_W-1:0] ibxU_reg;
  logic [DATA_W-1:0] ibxL_reg;
  logic [DATA_W-1:0] dbxU_reg;
  logic [DATA_W-1:0] dbxL_reg;
  logic [DATA_W-1:0] rdData_reg;
  logic [DATA_W-1:0] rdData_next;
  clic_state_t       state_reg;
  logic [SET_W-1:0]  sweep_reg;
  logic              flashStart;
  logic              dAllocValid_reg;
  logic [WAY_W-1:0]  dAllocWay_reg;
  logic              iAllocValid_reg;
  logic [WAY_W-1:0]  iAllocWay_reg;
  logic [DATA_W-1:0] fetchDwAddr_reg;
  logic              fetchSpec_reg;
  logic [WAY_W-1:0]  dLockCount;
  logic [WAY_W-1:0]  dVictim;
  logic [WAY_W-1:0]  iVictim;
  logic [ATTR_W-1:0] dAttr;
  logic [ATTR_W-1:0] iAttr;
  logic              dMissTake;
  logic              dAllocOk;
  logic              dBlkTake;
  logic              iAllocOk;
  logic              dWrEn;
  logic [SET_W-1:0]  dWrAddr;
  logic [WAYS-1:0]   dWrMask;
  logic [WAYS-1:0]   dWrData;
  logic              dLocked;

  // Register writes
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cfgA_reg   <= RST_CFG_A;
      cfgB_reg   <= RST_CFG_B;
      mstate_reg <= RST_MSTATE;
      ibxU_reg   <= RST_BX;
      ibxL_reg   <= RST_BX;
      dbxU_reg   <= RST_BX;
      dbxL_reg   <= RST_BX;
    end else if (ce && regWr) begin
      case (regAddr)
        OFS_CFG_A:  cfgA_reg   <= regWrData;
        OFS_CFG_B:  cfgB_reg   <= regWrData;
        OFS_MSTATE: mstate_reg <= regWrData;
        OFS_IBXU:   ibxU_reg   <= regWrData;
        OFS_IBXL:   ibxL_reg   <= regWrData;
        OFS_DBXU:   dbxU_reg   <= regWrData;
        OFS_DBXL:   dbxL_reg   <= regWrData;
        default:    ;
      endcase
    end
  end

  // Only the rising edge of the flash bit starts a sweep; clearing it does nothing
  assign flashStart = regWr && (regAddr == OFS_CFG_A) && regWrData[CFGA_FINV]
                      && !cfgA_reg[CFGA_FINV];

  // Register reads, data valid only in the cycle after the strobe
  always_comb begin
    rdData_next = '0;
    case (regAddr)
      OFS_CFG_A:  rdData_next = cfgA_reg;
      OFS_CFG_B:  rdData_next = cfgB_reg;
      OFS_MSTATE: rdData_next = mstate_reg;
      OFS_IBXU:   rdData_next = ibxU_reg;
      OFS_IBXL:   rdData_next = ibxL_reg;
      OFS_DBXU:   rdData_next = dbxU_reg;
      OFS_DBXL:   rdData_next = dbxL_reg;
      OFS_STATUS: begin
        rdData_next[STAT_BUSY] = (state_reg == ST_FLASH);
        rdData_next[STAT_VICT_LO +: WAY_W] = dVictim;
      end
      default:    rdData_next = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdData_reg <= '0;
    end else if (ce) begin
      rdData_reg <= regRd ? rdData_next : '0;
    end
  end

  assign regRdData = rdData_reg;

  // Mode outputs
  assign icacheEn       = cfgA_reg[CFGA_IC_EN];
  assign dcacheEn       = cfgA_reg[CFGA_DC_EN];
  assign dLocked        = cfgA_reg[CFGA_DLOCK];
  assign dLockCount     = cfgB_reg[CFGB_DWLK_LO +: WAY_W];
  assign instrXlateEn   = mstate_reg[MS_IXL];
  assign dataXlateEn    = mstate_reg[MS_DXL];
  assign externalIrqEn  = mstate_reg[MS_EXTI];
  assign machineCheckEn = mstate_reg[MS_MCHK];
  assign fpExcMode0     = mstate_reg[MS_FPX0];
  assign fpExcMode1     = mstate_reg[MS_FPX1];
  assign critIrqEn      = mstate_reg[MS_CE];

  // Flash sweep; also runs after reset so data-side valid bits never start unknown; the instruction-side valid bits are not swept
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg <= ST_FLASH;
      sweep_reg <= '0;
    end else if (ce) begin
      case (state_reg)
        ST_IDLE: begin
          if (flashStart) begin
            state_reg <= ST_FLASH;
            sweep_reg <= '0;
          end
        end
        ST_FLASH: begin
          sweep_reg <= sweep_reg + 7'h1;
          if (sweep_reg == LAST_SET) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          sweep_reg <= '0;
        end
      endcase
    end
  end

  // Translated attributes, same decoder for both sides
  assign dAttr = attrSel(dbxU_reg, dbxL_reg, dMissAddr, dataXlateEn, dMissPageAttr);
  assign iAttr = attrSel(ibxU_reg, ibxL_reg, iFillAddr, instrXlateEn, iFillPageAttr);

  // Misses and block invalidates wait out a sweep rather than race it
  assign dBlkInvReady = (state_reg == ST_IDLE);
  assign dMissReady   = (state_reg == ST_IDLE) && !dBlkInvValid;
  assign dBlkTake     = dBlkInvValid && dBlkInvReady;
  assign dMissTake    = dMissValid && dMissReady;
  assign dAllocOk     = dMissTake && dcacheEn && !dLocked && !dAttr[ATTR_INHIBIT];
  assign iAllocOk     = iFillValid && icacheEn && !iAttr[ATTR_INHIBIT];

  // One write port: sweep, then block invalidate, then allocation
  always_comb begin
    dWrEn   = 1'b0;
    dWrAddr = setOf(dMissAddr);
    dWrMask = '0;
    dWrData = '0;
    if (state_reg == ST_FLASH) begin
      dWrEn   = 1'b1;
      dWrAddr = sweep_reg;
      dWrMask = '1;
    end else if (dBlkTake) begin
      dWrEn   = 1'b1;
      dWrAddr = setOf(dBlkInvAddr);
      dWrMask = WAYS'(1) << dBlkInvWay;
    end else if (dAllocOk) begin
      dWrEn   = 1'b1;
      dWrMask = WAYS'(1) << dVictim;
      dWrData = '1;
    end
  end

  clic_victim u_dVictim (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .ce        (ce),
    .lockCount (dLockCount),
    .advance   (dAllocOk && (state_reg == ST_IDLE) && !dBlkTake),
    .victimWay (dVictim)
  );

  clic_victim u_iVictim (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .ce        (ce),
    .lockCount (3'h0),
    .advance   (iAllocOk),
    .victimWay (iVictim)
  );

  clic_valid_mem u_dValid (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .ce     (ce),
    .wrEn   (dWrEn),
    .wrAddr (dWrAddr),
    .wrMask (dWrMask),
    .wrData (dWrData),
    .rdAddr (setOf(dLookupAddr)),
    .rdData (dLookupValid)
  );

  // No cancel input: a prefetched line stays valid once allocated
  clic_valid_mem u_iValid (
    .mclk   (mclk),
    .rst_b  (rst_b),
    .ce     (ce),
    .wrEn   (iAllocOk),
    .wrAddr (setOf(iFillAddr)),
    .wrMask (WAYS'(1) << iVictim),
    .wrData ('1),
    .rdAddr (setOf(iLookupAddr)),
    .rdData (iLookupValid)
  );

  // Allocation reports
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dAllocValid_reg <= 1'b0;
      dAllocWay_reg   <= '0;
      iAllocValid_reg <= 1'b0;
      iAllocWay_reg   <= '0;
    end else if (ce) begin
      dAllocValid_reg <= dAllocOk && !dBlkTake;
      iAllocValid_reg <= iAllocOk;
      if (dAllocOk && !dBlkTake) begin
        dAllocWay_reg <= dVictim;
      end
      if (iAllocOk) begin
        iAllocWay_reg <= iVictim;
      end
    end
  end

  assign dAllocValid = dAllocValid_reg;
  assign dAllocWay   = dAllocWay_reg;
  assign iAllocValid = iAllocValid_reg;
  assign iAllocWay   = iAllocWay_reg;

  // Fetch address: whole aligned doubleword, redirected on a taken hint
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      fetchDwAddr_reg <= '0;
      fetchSpec_reg   <= 1'b0;
    end else if (ce) begin
      if (brValid && brTakenHint) begin
        fetchDwAddr_reg <= {brTarget[DATA_W-1:DW_OFFS_W], 3'h0};
        fetchSpec_reg   <= 1'b1;
      end else begin
        fetchDwAddr_reg <= {fetchPc[DATA_W-1:DW_OFFS_W], 3'h0};
        fetchSpec_reg   <= 1'b0;
      end
    end
  end

  assign fetchDwAddr = fetchDwAddr_reg;
  assign fetchSpec   = fetchSpec_reg;

endmodule : clic_ctrl

// file: tb/clic_ctrl_assertions.sv
/*
  Port-level checker for clic_ctrl: flash sweep timing, lock-aware allocation,
  attribute gating, state bits and fetch addressing.
  Assumes one clock, ce held high, bound into clic_ctrl by the testbench.
*/
`timescale 1ns/100ps
module clic_ctrl_assertions (
  input wire logic                        mclk,
  input wire logic                        rst_b,
  input wire logic [clic_pkg::ADDR_W-1:0] regAddr,
  input wire logic [clic_pkg::DATA_W-1:0] regWrData,
  input wire logic                        regWr,
  input wire logic                        dcacheEn,
  input wire logic                        instrXlateEn,
  input wire logic                        dataXlateEn,
  input wire logic                        externalIrqEn,
  input wire logic                        machineCheckEn,
  input wire logic                        fpExcMode0,
  input wire logic                        fpExcMode1,
  input wire logic                        critIrqEn,
  input wire logic                        dMissValid,
  input wire logic                        dMissReady,
  input wire logic [clic_pkg::ATTR_W-1:0] dMissPageAttr,
  input wire logic                        dAllocValid,
  input wire logic [clic_pkg::WAY_W-1:0]  dAllocWay,
  input wire logic                        dBlkInvReady,
  input wire logic [clic_pkg::DATA_W-1:0] fetchPc,
  input wire logic                        brValid,
  input wire logic                        brTakenHint,
  input wire logic [clic_pkg::DATA_W-1:0] brTarget,
  input wire logic [clic_pkg::DATA_W-1:0] fetchDwAddr,
  input wire logic                        fetchSpec
);
  import clic_pkg::*;
  logic [WAY_W-1:0]  lockCnt_reg;
  logic              finv_reg;
  logic [DATA_W-1:0] wd_reg;
  logic [DATA_W-1:0] pc_reg;
  logic [DATA_W-1:0] tgt_reg;
  // Shadow of the stored lock and flash bits, seen from the write port only
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      lockCnt_reg <= '0;
      finv_reg    <= 1'b0;
    end else if (regWr && regAddr == OFS_CFG_B) begin
      lockCnt_reg <= regWrData[CFGB_DWLK_LO +: WAY_W];
    end else if (regWr && regAddr == OFS_CFG_A) begin
      finv_reg <= regWrData[CFGA_FINV];
    end
  end
  always_ff @(posedge mclk) begin
    wd_reg  <= regWrData;
    pc_reg  <= fetchPc;
    tgt_reg <= brTarget;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_flash;
    regWr && regAddr == OFS_CFG_A && regWrData[CFGA_FINV] && !finv_reg && dBlkInvReady
      |=> !dBlkInvReady ##127 !dBlkInvReady ##1 dBlkInvReady;
  endproperty
  a_flash: assert property (p_flash) else $error("flash sweep length wrong");
  property p_lock;
    dAllocValid |-> dAllocWay >= lockCnt_reg;
  endproperty
  a_lock: assert property (p_lock) else $error("locked way allocated");
  property p_inhibit;
    dMissValid && dMissReady && dMissPageAttr[ATTR_INHIBIT] && !dataXlateEn |=> !dAllocValid;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibited line allocated");
  property p_dce;
    dMissValid && dMissReady && !dcacheEn |=> !dAllocValid;
  endproperty
  a_dce: assert property (p_dce) else $error("allocation with cache off");
  property p_xlate;
    regWr && regAddr == OFS_MSTATE
      |=> instrXlateEn == wd_reg[MS_IXL] && dataXlateEn == wd_reg[MS_DXL];
  endproperty
  a_xlate: assert property (p_xlate) else $error("translation enable wrong");
  property p_irq;
    regWr && regAddr == OFS_MSTATE |=> {externalIrqEn, machineCheckEn, fpExcMode0, fpExcMode1,
      critIrqEn} == {wd_reg[MS_EXTI], wd_reg[MS_MCHK], wd_reg[MS_FPX0], wd_reg[MS_FPX1],
      wd_reg[MS_CE]};
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt enable wrong");
  property p_fetch;
    !brValid |=> fetchDwAddr == {pc_reg[DATA_W-1:DW_OFFS_W], 3'h0} && !fetchSpec;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address wrong");
  property p_branch;
    brValid && brTakenHint |=> fetchSpec && fetchDwAddr == {tgt_reg[DATA_W-1:DW_OFFS_W], 3'h0};
  endproperty
  a_branch: assert property (p_branch) else $error("hinted branch not followed");
endmodule : clic_ctrl_assertions

// file: tb/tb.sv
/*
  Self-checking testbench for clic_ctrl, driving every port directly.
  Assumes the clic_pkg map and the hand-over timing; ce is held high.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb;
  import clic_pkg::*;
  logic mclk, rst_b, ce, regWr, regRd, dMissValid, dBlkInvValid, iFillValid, brValid, brTakenHint;
  logic icacheEn, dcacheEn, instrXlateEn, dataXlateEn, externalIrqEn, machineCheckEn, fpExcMode0;
  logic fpExcMode1, critIrqEn, dMissReady, dAllocValid, dBlkInvReady, iAllocValid, fetchSpec, ok;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWrData, regRdData, dMissAddr, dBlkInvAddr, dLookupAddr, iFillAddr;
  logic [DATA_W-1:0] iLookupAddr, fetchPc, brTarget, fetchDwAddr;
  logic [ATTR_W-1:0] dMissPageAttr, iFillPageAttr;
  logic [WAY_W-1:0]  dBlkInvWay, dAllocWay, iAllocWay, w1, w2;
  logic [WAYS-1:0]   dLookupValid, iLookupValid, dv, iv, dv9;
  int                n_fail, n_compared, cyc, n;
  clic_ctrl i_dut (.*);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // Hang guard; the whole run needs far fewer cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
    @(posedge mclk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 `CHK(nm, e, regRdData)
  endtask : rd
  // Holds the request until ready is seen at an edge, then reads the answer
  task automatic miss(input logic [DATA_W-1:0] a, input logic [ATTR_W-1:0] at);
    @(posedge mclk);
    dMissValid    <= 1'b1;
    dMissAddr     <= a;
    dMissPageAttr <= at;
    for (int i = 0; i < 300; i++) begin
      @(posedge mclk);
      if (dMissReady === 1'b1) break;
    end
    dMissValid <= 1'b0;
    #1 ok = dAllocValid;
    w1 = dAllocWay;
  endtask : miss
  task automatic blkinv(input logic [DATA_W-1:0] a, input logic [WAY_W-1:0] w);
    @(posedge mclk);
    dBlkInvValid <= 1'b1;
    dBlkInvAddr  <= a;
    dBlkInvWay   <= w;
    for (int i = 0; i < 300; i++) begin
      @(posedge mclk);
      if (dBlkInvReady === 1'b1) break;
    end
    dBlkInvValid <= 1'b0;
  endtask : blkinv
  task automatic look(input logic [DATA_W-1:0] a);
    @(posedge mclk);
    dLookupAddr <= a;
    iLookupAddr <= a;
    @(posedge mclk);
    #1 dv = dLookupValid;
    iv = iLookupValid;
  endtask : look
  task automatic ifill(input logic [DATA_W-1:0] a, input logic [ATTR_W-1:0] at);
    @(posedge mclk);
    iFillValid    <= 1'b1;
    iFillAddr     <= a;
    iFillPageAttr <= at;
    @(posedge mclk);
    iFillValid <= 1'b0;
    #1 ok = iAllocValid;
    w2 = iAllocWay;
  endtask : ifill
  task automatic t_regs();
    rd(OFS_STATUS, 32'h0000_0001, "status busy after reset");
    for (int i = 0; i < 200 && dBlkInvReady !== 1'b1; i++) @(posedge mclk);
    for (int a = 0; a < 32; a += 4) rd(a[ADDR_W-1:0], 32'h0000_0000, "reset value");
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0000_0000, "unmapped");
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rd(OFS_STATUS, 32'h0000_0000, "status read only");
    wr(OFS_IBXU, 32'hFFF0_001F);
    rd(OFS_IBXU, 32'hFFF0_001F, "entry upper");
    $display("test regs done");
  endtask : t_regs
  task automatic t_flash();
    wr(OFS_CFG_B, 32'h0000_0020);
    wr(OFS_CFG_A, 32'h0000_4000);
    `CHK("dcacheEn", 1'b1, dcacheEn)
    miss(32'h0000_0FE0, 4'h0);
    miss(32'h0000_0040, 4'h0);
    `CHK("alloc", 1'b1, ok)
    `CHK("way0 locked", 1'b1, w1 != 3'h0)
    look(32'h0000_005F);
    `CHK("same block", 1'b1, dv[w1])
    look(32'h0000_0060);
    `CHK("next block", 8'h00, dv)
    wr(OFS_CFG_A, 32'h0000_5000);
    miss(32'h0000_0080, 4'h0);
    `CHK("whole lock", 1'b0, ok)
    @(posedge mclk);
    regWr     <= 1'b1;
    regAddr   <= OFS_CFG_A;
    regWrData <= 32'h0000_5400;
    @(posedge mclk);
    regWr <= 1'b0;
    #1 n = 0;
    while (dBlkInvReady !== 1'b1 && n < 200) begin
      n++;
      @(posedge mclk);
      #1;
    end
    `CHK("sweep cycles", 128, n)
    wr(OFS_CFG_A, 32'h0000_5000);
    look(32'h0000_0040);
    `CHK("set 2 after flash", 8'h00, dv)
    look(32'h0000_0FE0);
    `CHK("set 127 after flash", 8'h00, dv)
    wr(OFS_CFG_A, 32'h0000_4000);
    wr(OFS_CFG_B, 32'h0000_00E0);
    for (int i = 0; i < 3; i++) begin
      miss(32'h0000_0200, 4'h0);
      `CHK("only way 7", 3'h7, w1)
    end
    $display("test flash done");
  endtask : t_flash
  task automatic t_blkinv();
    wr(OFS_CFG_B, 32'h0000_0000);
    miss(32'h0000_0100, 4'h0);
    w2 = w1;
    miss(32'h0000_0100, 4'h0);
    miss(32'h0000_0120, 4'h0);
    look(32'h0000_0120);
    dv9 = dv;
    blkinv(32'h0000_0100, w2);
    look(32'h0000_0100);
    `CHK("cleared way", 1'b0, dv[w2])
    `CHK("other way kept", 8'h02, dv)
    look(32'h0000_0120);
    `CHK("other set", dv9, dv)
    $display("test blkinv done");
  endtask : t_blkinv
  task automatic t_attr();
    wr(OFS_CFG_A, 32'h0000_C000);
    miss(32'h0000_0300, 4'h4);
    `CHK("inhibited", 1'b0, ok)
    miss(32'h0000_0300, 4'h5);
    `CHK("guarded io", 1'b0, ok)
    miss(32'h0000_0300, 4'h0);
    `CHK("allowed", 1'b1, ok)
    wr(OFS_DBXU, 32'hFFF0_001F);
    wr(OFS_DBXL, 32'hFFF0_0022);
    wr(OFS_IBXL, 32'hFFF0_0022);
    wr(OFS_MSTATE, 32'h0000_0030);
    `CHK("xlate", 2'b11, {instrXlateEn, dataXlateEn})
    miss(32'hFFF0_4000, 4'h0);
    `CHK("entry inhibits data", 1'b0, ok)
    ifill(32'hFFF0_4000, 4'h0);
    `CHK("entry inhibits instr", 1'b0, ok)
    miss(32'h0000_1000, 4'h0);
    `CHK("outside entry", 1'b1, ok)
    wr(OFS_DBXL, 32'hFFF0_0002);
    miss(32'hFFF0_4000, 4'h4);
    `CHK("entry allows", 1'b1, ok)
    wr(OFS_CFG_A, 32'h0000_8000);
    miss(32'h0000_1000, 4'h0);
    `CHK("cache off", 3'b100, {icacheEn, dcacheEn, ok})
    $display("test attr done");
  endtask : t_attr
  task automatic t_irq();
    wr(OFS_MSTATE, 32'h0000_99B0);
    `CHK("irq on", 5'h1F, {externalIrqEn, machineCheckEn, fpExcMode0, fpExcMode1,
      critIrqEn})
    wr(OFS_MSTATE, 32'h0000_99B0 & 32'hFFFF_667F);
    `CHK("irq off", 7'h03, {externalIrqEn, machineCheckEn, fpExcMode0, fpExcMode1, critIrqEn,
      instrXlateEn, dataXlateEn})
    $display("test irq done");
  endtask : t_irq
  task automatic t_fetch();
    wr(OFS_MSTATE, 32'h0000_0000);
    ifill(32'h0000_2000, 4'h0);
    `CHK("prefetch alloc", 1'b1, ok)
    @(posedge mclk);
    fetchPc     <= 32'h0000_1004;
    brValid     <= 1'b1;
    brTakenHint <= 1'b1;
    brTarget    <= 32'h0000_200C;
    @(posedge mclk);
    brTakenHint <= 1'b0;
    #1 `CHK("spec target", 33'h1_0000_2008, {fetchSpec, fetchDwAddr})
    @(posedge mclk);
    brValid <= 1'b0;
    #1 `CHK("no hint", 33'h0_0000_1000, {fetchSpec, fetchDwAddr})
    look(32'h0000_2000);
    `CHK("line kept", 1'b1, iv[w2])
    $display("test fetch done");
  endtask : t_fetch
  initial begin
    {rst_b, regWr, regRd, dMissValid, dBlkInvValid, iFillValid, brValid, brTakenHint} = '0;
    {regAddr, regWrData, dMissAddr, dBlkInvAddr, dLookupAddr, iFillAddr} = '0;
    {iLookupAddr, fetchPc, brTarget, dMissPageAttr, iFillPageAttr, dBlkInvWay} = '0;
    ce = 1'b1;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs();
    t_flash();
    t_blkinv();
    t_attr();
    t_irq();
    t_fetch();
    complete_run();
  end
endmodule : tb
bind clic_ctrl clic_ctrl_assertions i_chk (.*);
